// ==== atmc_defs.svh ====
// Constants for the acquisition and trigger mode control block.
`ifndef ATMC_DEFS_SVH
`define ATMC_DEFS_SVH
`define ATMC_CLK_MHZ          200
`define ATMC_NOTRIG_MS        2000
`define ATMC_AUTO_MS          500
`define ATMC_RIS_FORCE_MS     250
`define ATMC_ROLL_PAUSE_MS    200
`define ATMC_MS_CYCLES(ms)    ((ms) * `ATMC_CLK_MHZ * 1000)
`define ATMC_RIS_DEF_COUNT    10'h046
`define ATMC_SEG_DIVS         10
`define ATMC_MAX_PTS_2        16'h4e20
`define ATMC_MAX_PTS_5        16'h2710
`define ATMC_MAX_PTS_10       16'h1388
`define ATMC_MAX_PTS_20       16'h07d0
`define ATMC_MAX_PTS_50       16'h03e8
`define ATMC_MAX_PTS_100      16'h01f4
`define ATMC_MAX_PTS_200      16'h00c8
`define ATMC_SEG_2            8'h02
`define ATMC_SEG_5            8'h05
`define ATMC_SEG_10           8'h0a
`define ATMC_SEG_20           8'h14
`define ATMC_SEG_50           8'h32
`define ATMC_SEG_100          8'h64
`define ATMC_SEG_200          8'hc8
`endif

// ==== atmc_pkg.sv ====
// Types for the acquisition and trigger mode control block.
package atmc_pkg;
   typedef enum logic [3:0] {
      ATMC_MODE_SINGLE = 4'h1,
      ATMC_MODE_NORM   = 4'h2,
      ATMC_MODE_AUTO   = 4'h4,
      ATMC_MODE_SEQ    = 4'h8
   } atmc_mode_t;
   typedef enum logic [4:0] {
      ATMC_ST_ARMED = 5'h01,
      ATMC_ST_DELAY = 5'h02,
      ATMC_ST_DONE  = 5'h04,
      ATMC_ST_PAUSE = 5'h08,
      ATMC_ST_HOLD  = 5'h10
   } atmc_state_t;
   typedef struct packed {
      logic [15:0] pts_per_seg;
      logic [7:0]  seg_count;
      logic [9:0]  ris_count;
      logic        ris_on;
      logic        roll_on;
   } atmc_setup_t;
endpackage : atmc_pkg

// ==== atmc_ctrl.sv ====
// Acquisition and trigger mode sequencer.
`include "atmc_defs.svh"
// Behaviour
// RULE1: Normal mode shows record, restarts, re-arms.
// RULE2: Normal mode warns after two trigger-less seconds.
// RULE3: Single mode stops until hold pressed again.
// RULE4: Last record stays stored and shown.
// RULE5: Interleaved sampling collects set trigger count.
// RULE6: Roll completes capture, pauses, resumes rolling.
// RULE7: Hold press halts roll acquisition immediately; code halts only from armed state, already in single mode.
// RULE8: Auto mode forces trigger after 500 ms.
// RULE9: Auto interleaved forces display each quarter second.
// RULE10: Auto roll samples until mode changes.
// RULE11: Segment count is 2,5,10,20,50,100,200.
// RULE12: Segment spans ten divisions; time base fixed.
// RULE13: Points per segment capped by segment count.
// RULE14: Segmented display refreshes after all segments.
// RULE15: Sequence press ends early or re-arms.
// RULE16: Offset and vernier still apply after finish.
// RULE17: Other changes deferred; status still shows them.
// RULE18: Normal and auto apply changes immediately.
// RULE19: Done indication when capture completes.
// RULE20: Armed indication while armed and digitizing.
// RULE21: Keep digitizing until trigger delay satisfied.
// RULE22: Interleaved partial captures pulse trigger indication.
// RULE23: All channels recorded together always.
// RULE24: One mode at a time; change aborts capture.
module atmc_ctrl
   import atmc_pkg::*;
#(
   parameter int NOTRIG_CYCLES = `ATMC_MS_CYCLES(`ATMC_NOTRIG_MS),
   parameter int AUTO_CYCLES   = `ATMC_MS_CYCLES(`ATMC_AUTO_MS),
   parameter int RISF_CYCLES   = `ATMC_MS_CYCLES(`ATMC_RIS_FORCE_MS),
   parameter int PAUSE_CYCLES  = `ATMC_MS_CYCLES(`ATMC_ROLL_PAUSE_MS)
)
(
   // Clock and reset.
   input  wire logic        clock,
   input  wire logic        rst_n,
   // Front-panel buttons, already debounced pulses on this clock.
   input  wire logic        btn_single,
   input  wire logic        btn_norm,
   input  wire logic        btn_auto,
   input  wire logic        btn_seq,
   // Live front-panel settings.
   input  wire atmc_setup_t panel_setup,
   input  wire logic [7:0]  panel_offset,
   input  wire logic [7:0]  panel_vernier,
   // Trigger comparator and delay counter.
   input  wire logic        trig_valid,
   input  wire logic        delay_met,
   // Register bus.
   input  wire logic [3:0]  reg_addr,
   input  wire logic [31:0] reg_wdata,
   input  wire logic        reg_write,
   input  wire logic        reg_read,
   output logic      [31:0] reg_rdata,
   // Sample memory control.
   output logic             digitize,
   output logic             mem_all_channels,
   output logic             roll_scroll,
   output atmc_setup_t      acq_setup,
   output logic [7:0]       seg_index,
   // Display and status.
   output logic             display_update,
   output logic             record_valid,
   output logic [7:0]       shown_offset,
   output logic [7:0]       shown_vernier,
   output atmc_setup_t      status_setup,
   output logic             led_trigd,
   output logic             led_ready,
   output logic             warn_no_trig
);

   atmc_mode_t  mode;
   atmc_state_t state;
   logic [31:0] notrig_cnt;
   logic [31:0] auto_cnt;
   logic [31:0] risf_cnt;
   logic [31:0] pause_cnt;
   logic [9:0]  ris_got;
   logic [9:0]  ris_target;
   logic        mode_change;
   logic        roll_frozen;
   logic [15:0] cap_pts;
   logic [7:0]  seg_sel;
   logic        capture_end;
   logic        auto_fire;
   logic        ris_fire;
   logic        live_mode;

   // Mode buttons decode; a press of another mode counts as a change.
   assign mode_change = (btn_norm && mode != ATMC_MODE_NORM) ||
                        (btn_auto && mode != ATMC_MODE_AUTO) ||
                        (btn_single && mode != ATMC_MODE_SINGLE) ||
                        (btn_seq && mode != ATMC_MODE_SEQ);
   assign live_mode   = (mode == ATMC_MODE_NORM) || (mode == ATMC_MODE_AUTO);

   // Single active mode register; changing it aborts the capture.
   always_ff @(posedge clock)
   begin
      if (!rst_n)
         mode <= ATMC_MODE_NORM;
      else if (btn_single)
         mode <= ATMC_MODE_SINGLE; // RULE24
      else if (btn_norm)
         mode <= ATMC_MODE_NORM;
      else if (btn_auto)
         mode <= ATMC_MODE_AUTO;
      else if (btn_seq)
         mode <= ATMC_MODE_SEQ;
   end

   // Segment count is snapped to a legal value and capped in points.
   always_comb
   begin
      unique case (panel_setup.seg_count)
         `ATMC_SEG_2:   begin seg_sel = `ATMC_SEG_2;   cap_pts = `ATMC_MAX_PTS_2;   end
         `ATMC_SEG_5:   begin seg_sel = `ATMC_SEG_5;   cap_pts = `ATMC_MAX_PTS_5;   end
         `ATMC_SEG_10:  begin seg_sel = `ATMC_SEG_10;  cap_pts = `ATMC_MAX_PTS_10;  end
         `ATMC_SEG_20:  begin seg_sel = `ATMC_SEG_20;  cap_pts = `ATMC_MAX_PTS_20;  end
         `ATMC_SEG_50:  begin seg_sel = `ATMC_SEG_50;  cap_pts = `ATMC_MAX_PTS_50;  end
         `ATMC_SEG_100: begin seg_sel = `ATMC_SEG_100; cap_pts = `ATMC_MAX_PTS_100; end
         `ATMC_SEG_200: begin seg_sel = `ATMC_SEG_200; cap_pts = `ATMC_MAX_PTS_200; end
         default:       begin seg_sel = `ATMC_SEG_2;   cap_pts = `ATMC_MAX_PTS_2;   end
      endcase // RULE11 RULE13
   end

   // Settings reach the acquisition at once in live modes, else at re-arm.
   // The time base itself is never touched by the segment count. RULE12
   always_ff @(posedge clock)
   begin
      if (!rst_n)
      begin
         acq_setup            <= '0;
         acq_setup.seg_count  <= `ATMC_SEG_2;
         acq_setup.ris_count  <= `ATMC_RIS_DEF_COUNT;
      end
      else if (live_mode ||
               (state == ATMC_ST_ARMED && ris_got == 10'h000 && seg_index == 8'h00))
      begin
         acq_setup             <= panel_setup; // RULE18 RULE17
         acq_setup.seg_count   <= seg_sel;
         acq_setup.pts_per_seg <= (panel_setup.pts_per_seg > cap_pts) ?
                                  cap_pts : panel_setup.pts_per_seg; // RULE13
         if (panel_setup.ris_count == 10'h000)
            acq_setup.ris_count <= `ATMC_RIS_DEF_COUNT;
      end
   end

   // Status always mirrors the panel, even while changes are deferred.
   assign status_setup = panel_setup; // RULE17
   // Offset and vernier act on the shown record in every state.
   assign shown_offset  = panel_offset;  // RULE16
   assign shown_vernier = panel_vernier; // RULE16
   // Every channel is written on every sample regardless of display.
   assign mem_all_channels = digitize; // RULE23

   // Interleaved target count.
   assign ris_target = acq_setup.ris_count; // RULE5
   assign auto_fire  = (mode == ATMC_MODE_AUTO) && !acq_setup.ris_on &&
                       auto_cnt >= AUTO_CYCLES; // RULE8
   assign ris_fire   = (mode == ATMC_MODE_AUTO) && acq_setup.ris_on &&
                       risf_cnt >= RISF_CYCLES; // RULE9
   assign capture_end = (state == ATMC_ST_DELAY) && delay_met; // RULE21

   // Main acquisition sequencer.
   always_ff @(posedge clock)
   begin
      if (!rst_n)
      begin
         state     <= ATMC_ST_ARMED;
         ris_got   <= 10'h000;
         seg_index <= 8'h00;
      end
      else if (mode_change)
      begin
         state     <= ATMC_ST_ARMED; // RULE24
         ris_got   <= 10'h000;
         seg_index <= 8'h00;
      end
      else
      begin
         unique case (state)
            ATMC_ST_ARMED:
            begin
               if (btn_single && mode == ATMC_MODE_SINGLE)
                  state <= ATMC_ST_HOLD; // RULE7 RULE3
               else if (btn_seq && mode == ATMC_MODE_SEQ && seg_index != 8'h00)
                  state <= ATMC_ST_DONE; // RULE15
               else if (trig_valid || auto_fire || ris_fire)
                  state <= ATMC_ST_DELAY;
            end
            ATMC_ST_DELAY:
            begin
               if (delay_met)
               begin
                  if (acq_setup.ris_on && !ris_fire &&
                      ris_got + 10'h001 < ris_target)
                  begin
                     ris_got <= ris_got + 10'h001; // RULE5
                     state   <= ATMC_ST_ARMED;
                  end
                  else if (mode == ATMC_MODE_SEQ &&
                           seg_index + 8'h01 < acq_setup.seg_count)
                  begin
                     seg_index <= seg_index + 8'h01; // RULE14
                     state     <= ATMC_ST_ARMED;
                  end
                  else if (live_mode)
                  begin
                     ris_got <= 10'h000;
                     // Auto roll keeps sampling, so only normal roll pauses.
                     state   <= (acq_setup.roll_on && mode == ATMC_MODE_NORM) ?
                                ATMC_ST_PAUSE : ATMC_ST_ARMED; // RULE1 RULE6 RULE10
                  end
                  else
                     state <= ATMC_ST_DONE; // RULE3
               end
            end
            ATMC_ST_PAUSE:
            begin
               if (pause_cnt >= PAUSE_CYCLES)
                  state <= ATMC_ST_ARMED; // RULE6
            end
            ATMC_ST_DONE, ATMC_ST_HOLD:
            begin
               if ((btn_single && mode == ATMC_MODE_SINGLE) ||
                   (btn_seq && mode == ATMC_MODE_SEQ))
               begin
                  state     <= ATMC_ST_ARMED; // RULE3 RULE15
                  ris_got   <= 10'h000;
                  seg_index <= 8'h00;
               end
            end
         endcase
      end
   end

   // Digitizing runs in every state that waits for or completes a capture.
   // Auto roll never stops except by mode change. RULE10
   assign digitize    = (state == ATMC_ST_ARMED) || (state == ATMC_ST_DELAY);
   assign roll_scroll = acq_setup.roll_on && digitize;
   assign roll_frozen = state == ATMC_ST_HOLD;

   // Display refresh pulse on a completed or forced record.
   always_ff @(posedge clock)
   begin
      if (!rst_n)
         display_update <= 1'b0;
      else
         display_update <= !mode_change && capture_end &&
                           (ris_fire || !acq_setup.ris_on || ris_got + 10'h001 >= ris_target) &&
                           (mode != ATMC_MODE_SEQ ||
                            seg_index + 8'h01 >= acq_setup.seg_count); // RULE14 RULE9 RULE1
   end

   // Once any record exists it stays shown; only reset clears it. RULE4
   always_ff @(posedge clock)
   begin
      if (!rst_n)
         record_valid <= 1'b0;
      else if (display_update)
         record_valid <= 1'b1; // RULE4
   end

   // Trigger-done indication, also pulsed per interleaved partial capture.
   always_ff @(posedge clock)
   begin
      if (!rst_n)
         led_trigd <= 1'b0;
      else
         led_trigd <= !mode_change && capture_end; // RULE19 RULE22
   end

   // Armed indication.
   always_ff @(posedge clock)
   begin
      if (!rst_n)
         led_ready <= 1'b0;
      else
         led_ready <= (state == ATMC_ST_ARMED) && !roll_frozen; // RULE20
   end

   // Trigger-absence timers; each restarts on a real trigger.
   always_ff @(posedge clock)
   begin
      if (!rst_n || mode_change || trig_valid)
      begin
         notrig_cnt <= 32'h0000_0000;
         auto_cnt   <= 32'h0000_0000;
      end
      else
      begin
         if (notrig_cnt < NOTRIG_CYCLES)
            notrig_cnt <= notrig_cnt + 32'h0000_0001;
         if (auto_fire || state != ATMC_ST_ARMED)
            auto_cnt <= 32'h0000_0000;
         else
            auto_cnt <= auto_cnt + 32'h0000_0001;
      end
   end

   // Quarter-second forced display timer for auto interleaved sampling.
   // The force request holds until the forced record completes, so it cannot be lost.
   always_ff @(posedge clock)
   begin
      if (!rst_n || mode_change || (capture_end && ris_fire) || display_update)
         risf_cnt <= 32'h0000_0000;
      else
         risf_cnt <= risf_cnt + 32'h0000_0001;
   end

   // Roll pause timer.
   always_ff @(posedge clock)
   begin
      if (!rst_n || state != ATMC_ST_PAUSE)
         pause_cnt <= 32'h0000_0000;
      else
         pause_cnt <= pause_cnt + 32'h0000_0001;
   end

   // Warning only applies in normal mode.
   assign warn_no_trig = (mode == ATMC_MODE_NORM) && record_valid &&
                         notrig_cnt >= NOTRIG_CYCLES; // RULE2

   // Read-only status port; writes are accepted and ignored.
   always_ff @(posedge clock)
   begin
      if (!rst_n)
         reg_rdata <= 32'h0000_0000;
      else if (reg_read && reg_addr == 4'h0)
         reg_rdata <= {18'h00000, warn_no_trig, led_ready, led_trigd,
                       state, mode, 2'h0};
      else if (reg_read && reg_addr == 4'h1)
         reg_rdata <= {6'h00, ris_got, 8'h00, seg_index};
      else
         reg_rdata <= 32'h0000_0000;
   end

   logic unused_w;
   assign unused_w = ^{reg_write, reg_wdata};

endmodule : atmc_ctrl

// ==== atmc_ctrl_props.sv ====
// Port-level assertions for the acquisition and trigger mode sequencer.
module atmc_ctrl_props
   import atmc_pkg::*;
#(
   parameter int NOTRIG_CYCLES = 200,
   parameter int AUTO_CYCLES   = 50,
   parameter int RISF_CYCLES   = 25,
   parameter int PAUSE_CYCLES  = 20
)
(
   // Clock and reset.
   input  wire logic        clock,
   input  wire logic        rst_n,
   // Inputs watched.
   input  wire logic        delay_met,
   input  wire atmc_setup_t panel_setup,
   input  wire logic [7:0]  panel_offset,
   input  wire logic [7:0]  panel_vernier,
   // Outputs watched.
   input  wire logic        digitize,
   input  wire logic        mem_all_channels,
   input  wire logic        display_update,
   input  wire logic        record_valid,
   input  wire logic [7:0]  shown_offset,
   input  wire logic [7:0]  shown_vernier,
   input  wire atmc_setup_t status_setup,
   input  wire logic        led_trigd,
   input  wire logic        led_ready
);
   timeunit 1ns;
   timeprecision 100ps;
   // One clock domain, so clock and reset are given once for all checks.
   default clocking cb @(posedge clock); endclocking
   default disable iff (!rst_n);

   a_offset_follows: assert property (
      shown_offset == panel_offset && shown_vernier == panel_vernier)
      else $error("shown offset or vernier differs from the panel");
   a_status_live: assert property (status_setup == panel_setup)
      else $error("status setup does not follow the panel");
   a_all_channels: assert property (digitize |-> mem_all_channels)
      else $error("digitizing without all channels recorded");
   a_trigd_pulse: assert property (led_trigd |=> !led_trigd)
      else $error("trigger indication longer than one cycle");
   a_trigd_after_delay: assert property (led_trigd |-> $past(delay_met))
      else $error("capture completed before the delay was met");
   a_display_done: assert property (display_update |-> led_trigd)
      else $error("display refresh without done indication");
   a_display_pulse: assert property (display_update |=> !display_update)
      else $error("display refresh longer than one cycle");
   a_record_kept: assert property (record_valid |=> record_valid)
      else $error("stored record was dropped");
   a_ready_digitize: assert property (led_ready |-> $past(digitize))
      else $error("ready shown while not digitizing");
endmodule : atmc_ctrl_props

// ==== atmc_panel.sv ====
// Operator button and display refresh model facing the sequencer.
module atmc_panel
(
   // Clock.
   input  wire logic clock,
   // Refresh request from the block.
   input  wire logic display_update,
   // Mode buttons and refresh count.
   output logic      btn_single,
   output logic      btn_norm,
   output logic      btn_auto,
   output logic      btn_seq,
   output int        refreshes
);
   timeunit 1ns;
   timeprecision 100ps;
   // Buttons idle low; the display has drawn nothing yet.
   initial
   begin
      {btn_seq, btn_auto, btn_norm, btn_single} = 4'h0;
      refreshes = 0;
   end

   // The display redraws once per refresh pulse.
   always @(posedge clock)
      if (display_update === 1'b1)
         refreshes <= refreshes + 1;

   // A press lasts one cycle, so the block never sees a held button.
   task automatic press(input logic [3:0] code);
      @(posedge clock);
      {btn_seq, btn_auto, btn_norm, btn_single} <= code;
      @(posedge clock);
      {btn_seq, btn_auto, btn_norm, btn_single} <= 4'h0;
   endtask : press
endmodule : atmc_panel

// ==== tb_atmc_ctrl.sv ====
// Self-checking bench for the acquisition and trigger mode sequencer.
`include "atmc_defs.svh"
module tb_atmc_ctrl
   import atmc_pkg::*;
;
   timeunit 1ns;
   timeprecision 100ps;
   localparam int NOTRIG = 200;
   logic        clock, rst_n, trig_valid, delay_met, reg_write, reg_read;
   logic [3:0]  reg_addr;
   logic [31:0] reg_wdata, reg_rdata, d;
   logic [7:0]  panel_offset, panel_vernier, seg_index, shown_offset, shown_vernier;
   logic        btn_single, btn_norm, btn_auto, btn_seq, digitize, mem_all_channels;
   logic        roll_scroll, display_update, record_valid, led_trigd, led_ready, warn_no_trig;
   atmc_setup_t panel_setup, acq_setup, status_setup;
   int          err_total = 0, total_checks = 0, refreshes, cycles = 0, r;

   // Short counts keep the timeouts within a brief run.
   atmc_ctrl #(.NOTRIG_CYCLES(NOTRIG), .AUTO_CYCLES(50), .RISF_CYCLES(25),
      .PAUSE_CYCLES(20)) dut (.*);
   atmc_panel panel (.*);

   // Free-running clock.
   initial
   begin
      clock = 1'b0;
      forever #2.5 clock = ~clock;
   end

   task automatic chk(input bit ok, input string m);
      total_checks++;
      if (!ok)
         begin
            err_total++;
            $display("mismatch at %0t: %s", $time, m);
         end
   endtask : chk

   task automatic give_verdict;
      $display("checks %0d, mismatches %0d", total_checks, err_total);
      if (err_total == 0 && total_checks > 0)
         $display("ALL CHECKS OK");
      else
         $display("CHECKS NOT OK");
      $finish;
   endtask : give_verdict

   task automatic tick(input int n);
      repeat (n) @(negedge clock);
   endtask : tick

   // Read data stand only in the cycle after the strobe.
   task automatic rd(input logic [3:0] a);
      @(posedge clock);
      reg_addr <= a;
      reg_read <= 1'b1;
      @(posedge clock);
      reg_read <= 1'b0;
      @(negedge clock);
      d = reg_rdata;
   endtask : rd

   task automatic fire_trig;
      @(posedge clock);
      trig_valid <= 1'b1;
      @(posedge clock);
      trig_valid <= 1'b0;
   endtask : fire_trig

   task automatic fire_delay;
      @(posedge clock);
      delay_met <= 1'b1;
      @(posedge clock);
      delay_met <= 1'b0;
   endtask : fire_delay

   task automatic capture;
      fire_trig;
      fire_delay;
   endtask : capture

   task automatic t_reset;
      chk(acq_setup.seg_count === 8'h02, "reset segments");
      chk(acq_setup.ris_count === 10'h046, "reset trigger count");
      chk(digitize === 1'b1, "not digitizing");
      @(posedge clock);
      reg_wdata <= 32'hffffffff;
      reg_write <= 1'b1;
      @(posedge clock);
      reg_write <= 1'b0;
      rd(4'h0);
      chk(d[5:2] === 4'h2 && d[10:6] === ATMC_ST_ARMED, "reset mode");
      chk(d[12] === 1'b1, "reset not armed");
      rd(4'hf);
      chk(d === 32'h0, "unmapped read");
      $display("reset test done");
   endtask : t_reset

   task automatic t_norm;
      r = refreshes;
      capture;
      tick(3);
      chk(refreshes == r + 1 && record_valid === 1'b1, "normal capture");
      fire_trig;
      tick(10);
      chk(refreshes == r + 1 && digitize === 1'b1, "shown before delay");
      fire_delay;
      tick(3);
      rd(4'h0);
      chk(refreshes == r + 2 && d[10:6] === ATMC_ST_ARMED, "no rearm");
      tick(NOTRIG - 30);
      chk(warn_no_trig === 1'b0, "early warning");
      tick(40);
      chk(warn_no_trig === 1'b1, "missing warning");
      $display("normal test done");
   endtask : t_norm

   task automatic t_segments;
      logic [7:0]  s [8] = '{`ATMC_SEG_2, `ATMC_SEG_5, `ATMC_SEG_10, `ATMC_SEG_20,
         `ATMC_SEG_50, `ATMC_SEG_100, `ATMC_SEG_200, 8'h03};
      logic [15:0] c [8] = '{`ATMC_MAX_PTS_2, `ATMC_MAX_PTS_5, `ATMC_MAX_PTS_10,
         `ATMC_MAX_PTS_20, `ATMC_MAX_PTS_50, `ATMC_MAX_PTS_100, `ATMC_MAX_PTS_200,
         `ATMC_MAX_PTS_2};
      for (int i = 0; i < 8; i++)
      begin
         @(posedge clock);
         panel_setup <= '{16'hffff, s[i], 10'h046, 1'b0, 1'b0};
         tick(3);
         chk(acq_setup.seg_count === (i == 7 ? 8'h02 : s[i]), "segments");
         chk(acq_setup.pts_per_seg === c[i], "points cap");
      end
      $display("segment table test done");
   endtask : t_segments

   task automatic t_seq;
      @(posedge clock);
      panel_setup.seg_count <= `ATMC_SEG_5;
      tick(3);
      panel.press(4'h8);
      r = refreshes;
      repeat (4) capture;
      tick(3);
      chk(refreshes == r, "refresh before last segment");
      rd(4'h1);
      chk(d[7:0] === 8'h04 && seg_index === 8'h04, "segment index");
      capture;
      tick(3);
      rd(4'h0);
      chk(refreshes == r + 1 && d[10:6] === ATMC_ST_DONE, "sequence end");
      @(posedge clock);
      panel_setup.seg_count <= `ATMC_SEG_10;
      panel_offset <= 8'h5a;
      tick(3);
      chk(acq_setup.seg_count === `ATMC_SEG_5, "applied after finish");
      chk(status_setup.seg_count === `ATMC_SEG_10, "status stale");
      chk(shown_offset === 8'h5a, "offset ignored");
      panel.press(4'h8);
      rd(4'h0);
      chk(d[5:2] === 4'h8 && d[10:6] === ATMC_ST_ARMED, "sequence rearm");
      chk(acq_setup.seg_count === `ATMC_SEG_10, "deferred change lost");
      r = refreshes;
      repeat (2) capture;
      panel.press(4'h8);
      rd(4'h0);
      chk(refreshes == r && d[10:6] === ATMC_ST_DONE, "early end");
      $display("sequence test done");
   endtask : t_seq

   task automatic t_single;
      panel.press(4'h1);
      rd(4'h0);
      chk(d[5:2] === 4'h1 && d[10:6] === ATMC_ST_ARMED, "single select");
      r = refreshes;
      capture;
      tick(3);
      chk(refreshes == r + 1, "single capture");
      capture;
      tick(3);
      chk(refreshes == r + 1, "capture after hold");
      panel.press(4'h1);
      rd(4'h0);
      chk(d[10:6] === ATMC_ST_ARMED, "single rearm");
      $display("single test done");
   endtask : t_single

   task automatic t_auto;
      panel.press(4'h4);
      @(posedge clock);
      delay_met <= 1'b1;
      r = refreshes;
      tick(90);
      chk(refreshes > r, "no forced record");
      @(posedge clock);
      delay_met <= 1'b0;
      rd(4'h0);
      chk(d[5:2] === 4'h4, "auto select");
      $display("auto test done");
   endtask : t_auto

   // Interleaved: partial captures pulse, full set shows, auto forces a show.
   task automatic t_ris;
      @(posedge clock);
      panel_setup <= '{16'h0100, `ATMC_SEG_2, 10'h003, 1'b1, 1'b0};
      panel_vernier <= 8'h33;
      panel.press(4'h2);
      r = refreshes;
      repeat (2)
      begin
         capture;
         @(negedge clock);
         chk(led_trigd === 1'b1, "no partial capture pulse");
      end
      rd(4'h1);
      chk(d[25:16] === 10'h002 && refreshes == r, "partial count");
      capture;
      tick(3);
      chk(refreshes == r + 1, "reconstruction not shown");
      chk(shown_vernier === 8'h33, "vernier ignored");
      @(posedge clock);
      panel_setup.ris_count <= 10'h3ff;
      panel.press(4'h4);
      r = refreshes;
      @(posedge clock);
      delay_met <= 1'b1;
      tick(15);
      chk(refreshes == r, "early forced display");
      tick(20);
      chk(refreshes > r, "no forced display");
      @(posedge clock);
      delay_met <= 1'b0;
      $display("interleaved test done");
   endtask : t_ris

   // Roll: normal pauses then resumes, auto never stops, hold halts at once.
   task automatic t_roll;
      @(posedge clock);
      panel_setup <= '{16'h0100, `ATMC_SEG_2, 10'h046, 1'b0, 1'b1};
      panel.press(4'h2);
      tick(2);
      chk(roll_scroll === 1'b1, "not rolling");
      capture;
      @(negedge clock);
      chk(digitize === 1'b0, "no pause after capture");
      tick(15);
      chk(roll_scroll === 1'b0, "pause too short");
      tick(10);
      chk(roll_scroll === 1'b1, "roll not resumed");
      panel.press(4'h4);
      capture;
      @(negedge clock);
      chk(digitize === 1'b1, "auto roll stopped");
      panel.press(4'h1);
      panel.press(4'h1);
      @(negedge clock);
      chk(digitize === 1'b0, "hold did not halt");
      tick(1);
      chk(led_ready === 1'b0, "ready while held");
      panel.press(4'h1);
      tick(2);
      chk(led_ready === 1'b1, "hold not released");
      $display("roll test done");
   endtask : t_roll

   // Main sequence: inputs idle at time zero, ten cycles of reset.
   initial
   begin
      rst_n = 1'b0;
      trig_valid = 1'b0;
      delay_met = 1'b0;
      reg_addr = 4'h0;
      reg_wdata = 32'h0;
      reg_write = 1'b0;
      reg_read = 1'b0;
      panel_setup = '{16'h0100, 8'h02, 10'h046, 1'b0, 1'b0};
      panel_offset = 8'h00;
      panel_vernier = 8'h00;
      repeat (10) @(posedge clock);
      rst_n <= 1'b1;
      tick(2);
      t_reset;
      t_norm;
      t_segments;
      t_seq;
      t_single;
      t_auto;
      t_ris;
      t_roll;
      give_verdict;
   end

   // Hang guard; the tests need well under this many cycles.
   always @(posedge clock)
   begin
      cycles <= cycles + 1;
      if (cycles == 4000)
      begin
         err_total++;
         give_verdict;
      end
   end
endmodule : tb_atmc_ctrl

bind atmc_ctrl atmc_ctrl_props #(.NOTRIG_CYCLES(NOTRIG_CYCLES), .AUTO_CYCLES(AUTO_CYCLES),
   .RISF_CYCLES(RISF_CYCLES), .PAUSE_CYCLES(PAUSE_CYCLES)) u_props (.*);
